// file: rtl/lsq_map.svh
`ifndef LSQ_MAP_SVH
`define LSQ_MAP_SVH

// APB register byte offsets.
`define LSQ_CTRL_OFS        12'h000
`define LSQ_STATUS_OFS      12'h004
`define LSQ_ID_OFS          12'h008

// CTRL field positions and reset value.
`define LSQ_CTRL_RESTART    0
`define LSQ_CTRL_YEL_EN     1
`define LSQ_CTRL_RST        32'h0000_0002

// STATUS field positions.
`define LSQ_ST_CAUSE_LSB    0
`define LSQ_ST_SPECIAL      5
`define LSQ_ST_STARTUP      8
`define LSQ_ST_BOOT         9
`define LSQ_ST_PAT_LSB      16

// Timing: clock period and pattern times.
`define LSQ_CLK_PS          5000
`define LSQ_TICK_PS         1000000000
`define LSQ_FRAME_MS        1000
`define LSQ_HALF_MS         500
`define LSQ_BLINK_MS        100
`define LSQ_BLINK_STEP_MS   200
`define LSQ_FAST_MS         125
`define LSQ_FAST_ON_MS      62
`define LSQ_BOOT_FRAME_MS   1400
`define LSQ_FLASH_MS        50
`define LSQ_FLICKER_MS      20
`define LSQ_CMD_BLINK_MS    40
`define LSQ_STARTUP_PULSES  8

`endif

// file: rtl/lsq_pkg.sv
package lsq_pkg;

    // Controller state that the indicators render, all on the system clock.
    typedef struct packed {
        logic       usb_connected;  // Bus power and attach seen.
        logic       usb_recognized; // Host recognition message received.
        logic       usb_suspend;    // Bus suspended.
        logic       usb_activity;   // One-cycle pulse per USB transfer.
        logic       err_active;     // Any error condition present.
        logic       drv_energize;   // Enable command sent to the motor driver.
        logic       drv_step;       // One-cycle pulse per step command issued.
        logic       drv_dir_fwd;    // Direction command sent to the driver.
        logic       drv_fault;      // Driver over-current or over-temperature.
        logic       low_vin;        // Motor supply missing or too low.
        logic       cmd_deenergize; // De-energized by explicit command.
        logic       safe_start_only; // Safe start is the only error.
    } lsq_status_t;

    typedef struct packed {
        logic       active;         // Bootloader mode.
        logic       host_ack;       // Host acknowledged the bootloader.
        logic       fw_valid;       // Valid application firmware present.
        logic       usb_cmd;        // One-cycle pulse per USB command.
    } lsq_boot_t;

    // Reset cause flags as presented by the reset controller.
    typedef struct packed {
        logic       brownout;
        logic       watchdog;
        logic       software;
        logic       stack_over;
        logic       stack_under;
    } lsq_cause_t;

    typedef enum logic [3:0] {
        PAT_FWD,
        PAT_REV,
        PAT_ON,
        PAT_ON_OFF2,
        PAT_ON_OFF1,
        PAT_FAULT,
        PAT_LOWVIN,
        PAT_OFF_ON3,
        PAT_OFF_ON2,
        PAT_OFF_ON1,
        PAT_OFF
    } lsq_pat_t;

    typedef enum logic [1:0] {
        ST_CAPTURE,
        ST_STARTUP,
        ST_RUN
    } lsq_state_t;

endpackage : lsq_pkg

// file: rtl/lsq_status_led_sequencer.sv
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "lsq_map.svh"
// Function
// - Yellow pattern changes only after completing. A restart sets PAT_OFF at once instead.
// - Patterns follow driver commands, not feedback.
// - Classify last reset cause at startup.
// - Special reset: eight yellow pulses, red lit.
// - Startup blink: no commands, inputs, energizing.
// - Last reset cause readable as status.
// - Bootloader acknowledged: green double blink 1.4s.
// - Bootloader: yellow on, quick blink per command.
// - Bootloader: red lit iff no firmware.
// - Green shows USB connect, recognition, traffic, suspend.
// - Red follows the error signal.
// - Forward ramps up, reverse ramps down, 0.5s.
// - De-energized with driver fault: 8 blinks/s.
module lsq_status_led_sequencer #(
    parameter int unsigned MS_CYCLES = `LSQ_TICK_PS / `LSQ_CLK_PS,
    parameter logic [31:0] ID_VALUE  = 32'h0000_5A5A  // Arbitrary identification value.
) (
    input  wire logic                 mclk_in,          // System clock, 200 MHz.
    input  wire logic                 reset_in,         // Asynchronous reset, active high.
    input  wire lsq_pkg::lsq_status_t status_in,        // Controller status.
    input  wire lsq_pkg::lsq_boot_t   boot_in,          // Bootloader status.
    input  wire lsq_pkg::lsq_cause_t  cause_in,         // Reset cause flags.
    input  wire logic                 psel_in,          // APB select.
    input  wire logic                 penable_in,       // APB enable.
    input  wire logic                 pwrite_in,        // APB write.
    input  wire logic [11:0]          paddr_in,         // APB byte address.
    input  wire logic [31:0]          pwdata_in,        // APB write data.
    output logic [31:0]               prdata_out,       // APB read data.
    output logic                      pready_out,       // APB ready.
    output logic                      pslverr_out,      // APB error.
    output logic                      led_green_out,    // USB status LED.
    output logic                      led_red_out,      // Error LED.
    output logic                      led_yellow_out,   // Motor status LED.
    output logic                      cmd_hold_out,     // Command processing held off.
    output logic                      input_hold_out,   // Input sampling held off.
    output logic                      drv_allow_out     // Motor driver may be energized.
);

    localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);

    logic [17:0]         tick_cnt_ff;
    logic                ms_tick_ff;
    logic [10:0]         frame_ms_ff;
    logic [6:0]          fast_ms_ff;
    logic [10:0]         boot_ms_ff;
    logic [7:0]          pwm_ff;
    logic [3:0]          pulse_cnt_ff;
    logic [5:0]          flick_ms_ff;
    logic [5:0]          cmd_ms_ff;
    logic                moving_ff;
    logic                step_seen_ff;
    logic [31:0]         ctrl_ff;
    logic [4:0]          cause_ff;
    lsq_pkg::lsq_state_t state_ff;
    lsq_pkg::lsq_pat_t   pat_ff;
    lsq_pkg::lsq_pat_t   nxt_pat;
    logic                restart;
    logic                frame_end;
    logic                special;
    logic                apb_wr;
    logic                yel_bit;
    logic [7:0]          level;
    logic                fast_on;

    assign apb_wr    = psel_in & penable_in & pwrite_in;
    assign restart   = apb_wr && (paddr_in == `LSQ_CTRL_OFS)
                       && pwdata_in[`LSQ_CTRL_RESTART];
    assign frame_end = ms_tick_ff && (frame_ms_ff == 11'(`LSQ_FRAME_MS - 1));
    assign fast_on   = fast_ms_ff < 7'(`LSQ_FAST_ON_MS);
    assign special   = |cause_ff;

    function automatic logic blink_n(input logic [10:0] ms, input logic [1:0] n);
        logic r;
        r = (ms < 11'(`LSQ_BLINK_MS));
        if (n >= 2'd2 && ms >= 11'(`LSQ_BLINK_STEP_MS)
            && ms < 11'(`LSQ_BLINK_STEP_MS + `LSQ_BLINK_MS)) begin
            r = 1'b1;
        end
        if (n == 2'd3 && ms >= 11'(2 * `LSQ_BLINK_STEP_MS)
            && ms < 11'(2 * `LSQ_BLINK_STEP_MS + `LSQ_BLINK_MS)) begin
            r = 1'b1;
        end
        return r;
    endfunction : blink_n

    // Free-running millisecond tick; restart realigns it.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            tick_cnt_ff <= 18'h0;
            ms_tick_ff  <= 1'b0;
        end else if (restart || tick_cnt_ff == MS_LAST) begin
            tick_cnt_ff <= 18'h0;
            ms_tick_ff  <= ~restart;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 18'h1;
            ms_tick_ff  <= 1'b0;
        end
    end

    // Frame counters in milliseconds.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            frame_ms_ff <= 11'h0;
            fast_ms_ff  <= 7'h0;
            boot_ms_ff  <= 11'h0;
        end else if (restart) begin
            frame_ms_ff <= 11'h0;
            fast_ms_ff  <= 7'h0;
            boot_ms_ff  <= 11'h0;
        end else if (ms_tick_ff) begin
            frame_ms_ff <= frame_end ? 11'h0 : frame_ms_ff + 11'h1;
            fast_ms_ff  <= (fast_ms_ff == 7'(`LSQ_FAST_MS - 1)) ? 7'h0 : fast_ms_ff + 7'h1;
            boot_ms_ff  <= (boot_ms_ff == 11'(`LSQ_BOOT_FRAME_MS - 1)) ? 11'h0
                           : boot_ms_ff + 11'h1;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pwm_ff <= 8'h0;
        end else begin
            pwm_ff <= pwm_ff + 8'h1;
        end
    end

    // Reset cause capture and startup sequence.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff     <= lsq_pkg::ST_CAPTURE;
            cause_ff     <= 5'h0;
            pulse_cnt_ff <= 4'h0;
        end else begin
            case (state_ff)
                lsq_pkg::ST_CAPTURE: begin
                    cause_ff     <= cause_in;
                    pulse_cnt_ff <= 4'h0;
                    state_ff     <= (|cause_in) ? lsq_pkg::ST_STARTUP
                                                : lsq_pkg::ST_RUN;
                end
                lsq_pkg::ST_STARTUP: begin
                    if (restart) begin
                        pulse_cnt_ff <= 4'h0;
                    end else if (ms_tick_ff && fast_ms_ff == 7'(`LSQ_FAST_MS - 1)) begin
                        pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
                        if (pulse_cnt_ff == 4'(`LSQ_STARTUP_PULSES - 1)) begin
                            state_ff <= lsq_pkg::ST_RUN;
                        end
                    end
                end
                default: begin
                    state_ff <= lsq_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Motion is inferred from step commands issued within one frame.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            step_seen_ff <= 1'b0;
            moving_ff    <= 1'b0;
        end else if (frame_end || restart) begin
            step_seen_ff <= status_in.drv_step;
            moving_ff    <= step_seen_ff | status_in.drv_step;
        end else if (status_in.drv_step) begin
            step_seen_ff <= 1'b1;
            moving_ff    <= 1'b1;
        end
    end

    // Yellow pattern selection from driver commands.
    always_comb begin
        nxt_pat = lsq_pkg::PAT_OFF;
        if (status_in.drv_energize) begin
            if (moving_ff | status_in.drv_step) begin
                nxt_pat = status_in.drv_dir_fwd ? lsq_pkg::PAT_FWD
                                                : lsq_pkg::PAT_REV;
            end else if (status_in.err_active && status_in.safe_start_only) begin
                nxt_pat = lsq_pkg::PAT_ON_OFF1;
            end else if (status_in.err_active) begin
                nxt_pat = lsq_pkg::PAT_ON_OFF2;
            end else begin
                nxt_pat = lsq_pkg::PAT_ON;
            end
        end else if (status_in.drv_fault) begin
            nxt_pat = lsq_pkg::PAT_FAULT;
        end else if (status_in.low_vin) begin
            nxt_pat = lsq_pkg::PAT_LOWVIN;
        end else if (status_in.cmd_deenergize) begin
            nxt_pat = lsq_pkg::PAT_OFF_ON3;
        end else if (status_in.err_active && status_in.safe_start_only) begin
            nxt_pat = lsq_pkg::PAT_OFF_ON1;
        end else if (status_in.err_active) begin
            nxt_pat = lsq_pkg::PAT_OFF_ON2;
        end
    end

    // A new pattern is only latched at the end of a whole frame; a restart loads PAT_OFF at once.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pat_ff <= lsq_pkg::PAT_OFF;
        end else if (restart) begin
            pat_ff <= lsq_pkg::PAT_OFF;
        end else if (frame_end) begin
            pat_ff <= nxt_pat;
        end
    end

    // Retriggerable short-off timers for USB traffic and bootloader commands.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            flick_ms_ff <= 6'h0;
            cmd_ms_ff   <= 6'h0;
        end else begin
            if (status_in.usb_activity) begin
                flick_ms_ff <= 6'(`LSQ_FLICKER_MS);
            end else if (ms_tick_ff && flick_ms_ff != 6'h0) begin
                flick_ms_ff <= flick_ms_ff - 6'h1;
            end
            if (boot_in.usb_cmd) begin
                cmd_ms_ff <= 6'(`LSQ_CMD_BLINK_MS);
            end else if (ms_tick_ff && cmd_ms_ff != 6'h0) begin
                cmd_ms_ff <= cmd_ms_ff - 6'h1;
            end
        end
    end

    // Ramp brightness over the first half frame.
    always_comb begin
        level = 8'(frame_ms_ff >> 1);
        if (pat_ff == lsq_pkg::PAT_REV) begin
            level = 8'(`LSQ_HALF_MS / 2) - 8'(frame_ms_ff >> 1);
        end
    end

    always_comb begin
        yel_bit = 1'b0;
        case (pat_ff)
            lsq_pkg::PAT_FWD,
            lsq_pkg::PAT_REV:     yel_bit = (frame_ms_ff >= 11'(`LSQ_HALF_MS))
                                            || (pwm_ff < level);
            lsq_pkg::PAT_ON:      yel_bit = 1'b1;
            lsq_pkg::PAT_ON_OFF2: yel_bit = ~blink_n(frame_ms_ff, 2'd2);
            lsq_pkg::PAT_ON_OFF1: yel_bit = ~blink_n(frame_ms_ff, 2'd1);
            lsq_pkg::PAT_FAULT:   yel_bit = fast_on;
            lsq_pkg::PAT_LOWVIN:  yel_bit = frame_ms_ff < 11'(`LSQ_HALF_MS);
            lsq_pkg::PAT_OFF_ON3: yel_bit = blink_n(frame_ms_ff, 2'd3);
            lsq_pkg::PAT_OFF_ON2: yel_bit = blink_n(frame_ms_ff, 2'd2);
            lsq_pkg::PAT_OFF_ON1: yel_bit = blink_n(frame_ms_ff, 2'd1);
            default:              yel_bit = 1'b0;
        endcase
    end

    // LED drivers and hold-off outputs.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            led_green_out  <= 1'b0;
            led_red_out    <= 1'b0;
            led_yellow_out <= 1'b0;
            cmd_hold_out   <= 1'b1;
            input_hold_out <= 1'b1;
            drv_allow_out  <= 1'b0;
        end else if (restart) begin
            led_green_out  <= 1'b0;
            led_red_out    <= 1'b0;
            led_yellow_out <= 1'b0;
        end else if (state_ff != lsq_pkg::ST_RUN) begin
            led_green_out  <= 1'b0;
            led_red_out    <= (state_ff == lsq_pkg::ST_STARTUP);
            led_yellow_out <= (state_ff == lsq_pkg::ST_STARTUP) && fast_on;
            cmd_hold_out   <= 1'b1;
            input_hold_out <= 1'b1;
            drv_allow_out  <= 1'b0;
        end else if (boot_in.active) begin
            led_green_out  <= boot_in.host_ack
                              ? blink_n(boot_ms_ff, 2'd2)
                              : frame_ms_ff < 11'(`LSQ_HALF_MS);
            led_red_out    <= ~boot_in.fw_valid;
            led_yellow_out <= (cmd_ms_ff == 6'h0);
            cmd_hold_out   <= 1'b0;
            input_hold_out <= 1'b0;
            drv_allow_out  <= 1'b0;
        end else begin
            if (status_in.usb_suspend || !status_in.usb_connected) begin
                led_green_out <= 1'b0;
            end else if (!status_in.usb_recognized) begin
                led_green_out <= frame_ms_ff < 11'(`LSQ_HALF_MS);
            end else begin
                led_green_out <= (flick_ms_ff == 6'h0);
            end
            led_red_out    <= status_in.err_active;
            led_yellow_out <= yel_bit & ctrl_ff[`LSQ_CTRL_YEL_EN];
            cmd_hold_out   <= 1'b0;
            input_hold_out <= 1'b0;
            drv_allow_out  <= 1'b1;
        end
    end

    // APB control register; the restart bit is a write-only strobe.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_ff <= `LSQ_CTRL_RST;
        end else if (apb_wr && paddr_in == `LSQ_CTRL_OFS) begin
            ctrl_ff <= {30'h0, pwdata_in[`LSQ_CTRL_YEL_EN], 1'b0};
        end
    end

    always_comb begin
        prdata_out  = 32'h0;
        pslverr_out = 1'b0;
        pready_out  = 1'b1;
        if (paddr_in == `LSQ_CTRL_OFS) begin
            prdata_out = ctrl_ff;
        end else if (paddr_in == `LSQ_STATUS_OFS) begin
            prdata_out[`LSQ_ST_CAUSE_LSB +: 5] = cause_ff;
            prdata_out[`LSQ_ST_SPECIAL]        = special;
            prdata_out[`LSQ_ST_STARTUP]        = (state_ff != lsq_pkg::ST_RUN);
            prdata_out[`LSQ_ST_BOOT]           = boot_in.active;
            prdata_out[`LSQ_ST_PAT_LSB +: 4]   = pat_ff;
        end else if (paddr_in == `LSQ_ID_OFS) begin
            prdata_out = ID_VALUE;
        end else begin
            pslverr_out = psel_in & penable_in;
        end
    end

endmodule : lsq_status_led_sequencer

// file: verif/lsq_props.sv
`timescale 1ns/10ps
module lsq_props #(
    parameter logic [31:0] ID_VALUE = 32'h0000_5A5A
) (
    input wire logic                 mclk_in,        // Clock.
    input wire logic                 reset_in,       // Reset.
    input wire lsq_pkg::lsq_status_t status_in,      // Status.
    input wire lsq_pkg::lsq_boot_t   boot_in,        // Bootloader.
    input wire logic                 psel_in,        // APB select.
    input wire logic                 penable_in,     // APB enable.
    input wire logic                 pwrite_in,      // APB write.
    input wire logic [11:0]          paddr_in,       // APB address.
    input wire logic [31:0]          pwdata_in,      // APB write data.
    input wire logic [31:0]          prdata_out,     // APB read data.
    input wire logic                 pready_out,     // APB ready.
    input wire logic                 pslverr_out,    // APB error.
    input wire logic                 led_green_out,  // Green LED.
    input wire logic                 led_red_out,    // Red LED.
    input wire logic                 led_yellow_out, // Yellow LED.
    input wire logic                 cmd_hold_out,   // Command hold.
    input wire logic                 input_hold_out, // Input hold.
    input wire logic                 drv_allow_out   // Driver allowed.
);
    logic [1:0] rs_ff;
    logic       acc;
    assign acc = psel_in && penable_in;
    // A restart blanks the LEDs briefly, so the red and green relations skip those cycles; a_boot_cmd does not.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) rs_ff <= 2'h0;
        else rs_ff <= {rs_ff[0], acc && pwrite_in && paddr_in == 12'h000 && pwdata_in[0]};
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    a_ready_high: assert property (acc |-> pready_out) else $error("pready low");
    a_bad_addr: assert property (acc && paddr_in > 12'h008 |->
        pslverr_out && (pwrite_in || prdata_out == 32'h0)) else $error("unmapped access");
    a_good_addr: assert property (acc && paddr_in inside {12'h000, 12'h004, 12'h008}
        |-> !pslverr_out) else $error("mapped access error");
    a_id_read: assert property (acc && !pwrite_in && paddr_in == 12'h008 |->
        prdata_out == ID_VALUE) else $error("id value");
    a_hold_drive: assert property (input_hold_out |-> !drv_allow_out)
        else $error("driver allowed in hold");
    a_hold_pair: assert property (cmd_hold_out == input_hold_out)
        else $error("holds differ");
    a_red_follow: assert property ($past(!input_hold_out && !boot_in.active) && rs_ff == 2'h0
        |-> led_red_out == $past(status_in.err_active)) else $error("red vs error");
    a_boot_red: assert property ($past(!input_hold_out && boot_in.active) && rs_ff == 2'h0
        |-> led_red_out == !$past(boot_in.fw_valid)) else $error("boot red");
    a_green_susp: assert property ($past(!input_hold_out && !boot_in.active &&
        status_in.usb_suspend) && rs_ff == 2'h0 |-> !led_green_out) else $error("green on");
    a_boot_cmd: assert property ($past(!input_hold_out && boot_in.active && boot_in.usb_cmd)
        |=> !led_yellow_out [*4]) else $error("yellow not off after command");
endmodule : lsq_props
bind lsq_status_led_sequencer lsq_props #(.ID_VALUE(ID_VALUE)) i_lsq_props (.*);

// file: verif/lsq_led_view.sv
`timescale 1ns/10ps
module lsq_led_view (
    input wire logic  mclk_in,         // Clock.
    input wire logic  clr_in,          // Clear counts.
    input wire logic  led_green_in,    // Green LED.
    input wire logic  led_yellow_in,   // Yellow LED.
    output logic [7:0] green_rise_out, // Green flashes seen.
    output logic [7:0] yellow_rise_out // Yellow flashes seen.
);
    logic g_ff;
    logic y_ff;
    // The viewer counts each turn-on of an LED as one flash.
    always_ff @(posedge mclk_in) begin
        g_ff <= led_green_in;
        y_ff <= led_yellow_in;
        if (clr_in) begin
            green_rise_out  <= 8'h00;
            yellow_rise_out <= 8'h00;
        end else begin
            green_rise_out  <= green_rise_out + 8'(led_green_in && !g_ff);
            yellow_rise_out <= yellow_rise_out + 8'(led_yellow_in && !y_ff);
        end
    end
endmodule : lsq_led_view

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
    localparam int MS = 4;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    lsq_pkg::lsq_status_t st  = '0;
    lsq_pkg::lsq_boot_t   bt  = '0;
    lsq_pkg::lsq_cause_t  cs  = '0;
    logic                 psel = 1'b0, pen = 1'b0, pwr = 1'b0, clr = 1'b0, e;
    logic [11:0]          pa  = 12'h000;
    logic [31:0]          pwd = 32'h0, rd, prd;
    logic                 prdy, perr, lg, lr, ly, chold, ihold, dallow;
    logic [7:0]           g_n, y_n;
    int                   errors = 0, check_count = 0, cycles = 0, n, bad;
    always #2.5 clk = ~clk;
    lsq_status_led_sequencer #(.MS_CYCLES(MS), .ID_VALUE(32'h0000_1234)) i_lsq_status_led_sequencer (
        .mclk_in(clk), .reset_in(rst), .status_in(st), .boot_in(bt), .cause_in(cs),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .led_green_out(lg),
        .led_red_out(lr), .led_yellow_out(ly), .cmd_hold_out(chold),
        .input_hold_out(ihold), .drv_allow_out(dallow));
    lsq_led_view i_lsq_led_view (.mclk_in(clk), .clr_in(clr), .led_green_in(lg),
        .led_yellow_in(ly), .green_rise_out(g_n), .yellow_rise_out(y_n));
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rd = prd;
        e  = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    task automatic pulse_clr;
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
    endtask : pulse_clr
    task automatic do_reset(input logic [4:0] c);
        rst <= 1'b1;
        cs  <= c;
        clr <= 1'b1;
        cyc(5);
        rst <= 1'b0;
        clr <= 1'b0;
    endtask : do_reset
    task automatic wait_pat(input logic [3:0] p);
        int k;
        k = 0;
        do begin
            apb(1'b0, 12'h004, 32'h0);
            k++;
        end while (rd[19:16] !== p && k < 3000);
        chk(rd[19:16], p, "pattern not reached");
    endtask : wait_pat
    task automatic t_regs;
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0000_1234, "id");
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0002, "ctrl reset");
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd[5:0], 6'h00, "status after clean reset");
        apb(1'b0, 12'h00C, 32'h0);
        chk({rd[0], e}, 2'b01, "unmapped read");
        $display("t_regs end");
    endtask : t_regs
    task automatic t_red;
        st.err_active <= 1'b1;
        cyc(3);
        chk(lr, 1'b1, "red on");
        st.err_active <= 1'b0;
        cyc(3);
        chk(lr, 1'b0, "red off");
        $display("t_red end");
    endtask : t_red
    task automatic t_green;
        st.usb_connected  <= 1'b1;
        st.usb_recognized <= 1'b1;
        cyc(3);
        chk(lg, 1'b1, "green on");
        st.usb_activity <= 1'b1;
        cyc(1);
        st.usb_activity <= 1'b0;
        cyc(2);
        chk(lg, 1'b0, "green flicker");
        cyc(MS * 25);
        chk(lg, 1'b1, "green back");
        st.usb_recognized <= 1'b0;
        pulse_clr();
        cyc(MS * 1000);
        chk(g_n, 8'd1, "slow blink");
        st.usb_suspend <= 1'b1;
        cyc(3);
        chk(lg, 1'b0, "suspend");
        st <= '0;
        $display("t_green end");
    endtask : t_green
    task automatic t_fault;
        st.drv_fault <= 1'b1;
        cyc(1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd[19:16], lsq_pkg::PAT_OFF, "pattern changed early");
        wait_pat(lsq_pkg::PAT_FAULT);
        pulse_clr();
        cyc(MS * 1010);
        chk(y_n, 8'd8, "fault blinks");
        st <= '0;
        $display("t_fault end");
    endtask : t_fault
    task automatic t_move(input logic fwd, input logic [3:0] p);
        st.drv_energize <= 1'b1;
        st.drv_dir_fwd  <= fwd;
        st.drv_step     <= 1'b1;
        cyc(1);
        st.drv_step <= 1'b0;
        wait_pat(p);
        n = 0;
        repeat (160) begin
            @(posedge clk);
            n += ly;
        end
        chk(fwd ? n < 40 : n > 120, 1'b1, "ramp start");
        cyc(MS * 510);
        n = 0;
        repeat (MS * 400) begin
            @(posedge clk);
            n += ly;
        end
        chk(n, MS * 400, "full brightness half");
        $display("t_move end");
    endtask : t_move
    task automatic t_restart;
        st <= '0;
        apb(1'b1, 12'h000, 32'h0000_0003);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0002, "ctrl after restart");
        apb(1'b0, 12'h004, 32'h0);
        chk(rd[19:16], lsq_pkg::PAT_OFF, "pattern after restart");
        $display("t_restart end");
    endtask : t_restart
    task automatic t_boot;
        bt <= 4'hC;
        cyc(3);
        chk(lr, 1'b1, "no firmware");
        bt.fw_valid <= 1'b1;
        cyc(2);
        chk(lr, 1'b0, "firmware present");
        pulse_clr();
        cyc(MS * 1400);
        chk(g_n, 8'd2, "double blink");
        chk(ly, 1'b1, "boot yellow on");
        bt.usb_cmd <= 1'b1;
        cyc(1);
        bt.usb_cmd <= 1'b0;
        cyc(2);
        chk(ly, 1'b0, "command blink");
        cyc(MS * 45);
        chk(ly, 1'b1, "yellow back");
        bt <= '0;
        $display("t_boot end");
    endtask : t_boot
    task automatic t_cause;
        for (int i = 0; i < 5; i++) begin
            do_reset(5'(1 << i));
            cyc(3);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd[5:0], {1'b1, 5'(1 << i)}, "cause");
            chk({rd[8], chold, dallow}, 3'b110, "startup hold");
        end
        st.drv_energize <= 1'b1;
        n = 0;
        bad = 0;
        while (ihold === 1'b1 && n < 6000) begin
            bad += (lr !== 1'b1);
            @(negedge clk);
            n++;
        end
        chk(y_n, 8'd8, "startup pulses");
        chk(dallow, 1'b1, "driver allowed after startup");
        chk(bad, 0, "red during startup");
        chk(n > 3800 && n < 4100, 1'b1, "startup length");
        $display("t_cause end");
    endtask : t_cause
    initial begin
        do_reset(5'h00);
        cyc(3);
        t_regs();
        t_red();
        t_green();
        t_fault();
        t_move(1'b1, lsq_pkg::PAT_FWD);
        t_move(1'b0, lsq_pkg::PAT_REV);
        t_restart();
        t_boot();
        t_cause();
        test_done();
    end
endmodule : tb
